// [ddr3_init_defs.svh]
// Constants for the memory reset and initialization controller
// How it works
// - Activate carries bank on bank lines and row on address bus.
// - A row must be opened before reading or writing its bank. The controller still issues such a command and only sets OPEN_ERR.
// - Read/write address gives column, A10 auto precharge, A12 burst chop.
// - Power-up reset held 200 us; clock enable low 10 ns before release.
// - Wait 500 us after reset release before raising clock enable.
// - Clock runs max(10 ns, 5 clocks) with no-op shown before clock enable.
// - Clock enable stays high until initialization ends.
// - Termination control pin held static low during initialization.
// - Wait reset exit time, max(self-refresh exit, 5 clocks), before first mode write.
// - Mode registers written in order 2, 3, 1, 0 with full settings.
// - Bank lines select mode register: 2 is 010, 3 is 011.
// - Register 1 write enables the DLL: A0 low, bank 001.
// - Register 0 write resets the DLL: A8 high, bank 000.
// - Long calibration after register 0, then wait lock and calibration times.
// - Only no-op between mode writes and long calibration.
// - Warm reset held 100 ns, clock enable low before, then repeat steps.
// - Mode write cycle time separates consecutive mode writes.
// - Mode write drives select, row, column and write strobes low.
`ifndef DDR3_INIT_DEFS_SVH
`define DDR3_INIT_DEFS_SVH
`define CLK_PERIOD_PS 10000
`define T_RESET_COLD_NS 200000
`define T_RESET_WARM_NS 100
`define T_CKE_SETUP_NS 10
`define T_RESET_EXIT_NS 500000
`define T_CLK_STABLE_NS 10
`define T_CLK_STABLE_TCK 5
`define T_XS_NS 270
`define T_XPR_TCK 5
`define T_MRD_TCK 4
`define T_ZQINIT_TCK 512
`define T_DLLK_TCK 512
`define CK_DIV_HALF 8
`define BANK_MR0 3'h0
`define BANK_MR1 3'h1
`define BANK_MR2 3'h2
`define BANK_MR3 3'h3
`define ADDR_DLL_RESET_BIT 8
`define ADDR_DLL_DIS_BIT 0
`define ADDR_ZQ_LONG_BIT 10
`endif

// [ddr3_init_pkg.sv]
// Types for the memory reset and initialization controller
package ddr3_init_pkg;
  typedef enum logic [3:0] {
    CMD_NOP, CMD_MRS, CMD_ZQCL, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF
  } cmd_e;
  typedef enum logic [3:0] {
    ST_RESET, ST_CKE_LOW, ST_EXIT_WAIT, ST_CKE_UP, ST_XPR, ST_MR2, ST_MR3,
    ST_MR1, ST_MR0, ST_ZQCL, ST_LOCK, ST_READY
  } state_e;
  function automatic logic [3:0] cmd_pins(input cmd_e c);
    // Returns {cs_n, ras_n, cas_n, we_n}
    unique case (c)
      CMD_MRS: return 4'h0;
      CMD_ZQCL: return 4'h6;
      CMD_ACT: return 4'h3;
      CMD_RD: return 4'h5;
      CMD_WR: return 4'h4;
      CMD_PRE: return 4'h2;
      CMD_REF: return 4'h1;
      default: return 4'h7;
    endcase
  endfunction
endpackage

// [ddr3_ck_div.sv]
// Divider that makes the memory command clock
`timescale 1ns/1ps
module ddr3_ck_div
  import ddr3_init_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic run,
  output logic ck,
  output logic rise
);
`include "ddr3_init_defs.svh"
  logic [3:0] cnt_q;
  logic ck_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= 4'h0;
      ck_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= 4'h0;
      ck_q <= 1'b0;
    end else if (cnt_q == 4'(`CK_DIV_HALF - 1)) begin
      cnt_q <= 4'h0;
      ck_q <= ~ck_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign ck = ck_q;
  // Commands change just after a falling edge so they are stable at the next rise
  assign rise = run && ck_q && (cnt_q == 4'(`CK_DIV_HALF - 1));
endmodule

// [ddr3_wait_timer.sv]
// Down counter for sequencer waits
`timescale 1ns/1ps
module ddr3_wait_timer (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic load,
  input wire logic [31:0] count,
  input wire logic tick,
  output logic done
);
  logic [31:0] rem_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rem_q <= 32'h0000_0000;
    end else if (load) begin
      rem_q <= count;
    end else if (tick && rem_q != 32'h0000_0000) begin
      rem_q <= rem_q - 32'h0000_0001;
    end
  end
  // Done ignores load so a reload in the same cycle forms no combinational loop
  assign done = (rem_q == 32'h0000_0000);
endmodule

// [ddr3_init_ctrl.sv]
// Controller that resets and initializes the memory and then passes user commands
`timescale 1ns/1ps
`include "ddr3_init_defs.svh"
module ddr3_init_ctrl
  import ddr3_init_pkg::*;
#(
  parameter int RESET_COLD_CYC = (`T_RESET_COLD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS,
  parameter int RESET_EXIT_CYC = (`T_RESET_EXIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS
)(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WARM_RESET,
  input wire logic [15:0] MR0_VAL,
  input wire logic [15:0] MR1_VAL,
  input wire logic [15:0] MR2_VAL,
  input wire logic [15:0] MR3_VAL,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [2:0] REQ_CMD,
  input wire logic [2:0] REQ_BANK,
  input wire logic [15:0] REQ_ADDR,
  output logic INIT_DONE,
  output logic OPEN_ERR,
  output logic MEM_RESET_N,
  output logic MEM_CK,
  output logic MEM_CKE,
  output logic MEM_CS_N,
  output logic MEM_RAS_N,
  output logic MEM_CAS_N,
  output logic MEM_WE_N,
  output logic [2:0] MEM_BA,
  output logic [15:0] MEM_A,
  output logic MEM_ODT
);
  // ==========================================================
  // Wait counts in controller clocks and memory command clocks
  // ==========================================================
  function automatic int ns_cyc(input int ns);
    return (ns * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
  endfunction
  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction
  localparam int WARM_CYC = ns_cyc(`T_RESET_WARM_NS);
  localparam int SETUP_CYC = ns_cyc(`T_CKE_SETUP_NS);
  localparam int TCK_CYC = 2 * `CK_DIV_HALF;
  localparam int STABLE_CK = max2((ns_cyc(`T_CLK_STABLE_NS) + TCK_CYC - 1) / TCK_CYC, `T_CLK_STABLE_TCK);
  localparam int XS_CK = (ns_cyc(`T_XS_NS) + TCK_CYC - 1) / TCK_CYC;
  localparam int XPR_CK = max2(XS_CK, `T_XPR_TCK);
  localparam int LOCK_CK = max2(`T_DLLK_TCK, `T_ZQINIT_TCK);

  // ==========================================================
  // Command clock and timers
  // ==========================================================
  state_e state_q;
  logic ck_run;
  logic ck_rise;
  logic sys_load;
  logic [31:0] sys_count;
  logic sys_done;
  logic ck_load;
  logic [31:0] ck_count;
  logic ck_done;
  logic [31:0] hold_q;
  logic [7:0] open_q;

  assign ck_run = (state_q != ST_RESET) && (state_q != ST_CKE_LOW);

  ddr3_ck_div u_div (
    .CLK(CLK),
    .RST_N(RST_N),
    .run(ck_run),
    .ck(MEM_CK),
    .rise(ck_rise)
  );

  ddr3_wait_timer u_sys_timer (
    .CLK(CLK),
    .RST_N(RST_N),
    .load(sys_load),
    .count(sys_count),
    .tick(1'b1),
    .done(sys_done)
  );

  ddr3_wait_timer u_ck_timer (
    .CLK(CLK),
    .RST_N(RST_N),
    .load(ck_load),
    .count(ck_count),
    .tick(ck_rise),
    .done(ck_done)
  );

  // ==========================================================
  // Sequencer
  // ==========================================================
  state_e state_d;
  logic issue;
  always_comb begin
    state_d = state_q;
    sys_load = 1'b0;
    sys_count = 32'h0000_0000;
    ck_load = 1'b0;
    ck_count = 32'h0000_0000;
    issue = 1'b0;
    unique case (state_q)
      ST_RESET: begin
        if (hold_q == 32'h0000_0000) begin
          state_d = ST_CKE_LOW;
          sys_load = 1'b1;
          sys_count = 32'(SETUP_CYC);
        end
      end
      ST_CKE_LOW: begin
        if (sys_done) begin
          state_d = ST_EXIT_WAIT;
          sys_load = 1'b1;
          sys_count = 32'(RESET_EXIT_CYC);
          ck_load = 1'b1;
          ck_count = 32'(STABLE_CK);
        end
      end
      ST_EXIT_WAIT: begin
        if (sys_done && ck_done && ck_rise) begin
          state_d = ST_CKE_UP;
        end
      end
      ST_CKE_UP: begin
        if (ck_rise) begin
          state_d = ST_XPR;
          ck_load = 1'b1;
          ck_count = 32'(XPR_CK);
        end
      end
      ST_XPR, ST_MR2, ST_MR3, ST_MR1, ST_MR0: begin
        if (ck_done && ck_rise) begin
          issue = 1'b1;
          ck_load = 1'b1;
          ck_count = 32'(`T_MRD_TCK);
          unique case (state_q)
            ST_XPR: state_d = ST_MR2;
            ST_MR2: state_d = ST_MR3;
            ST_MR3: state_d = ST_MR1;
            ST_MR1: state_d = ST_MR0;
            default: state_d = ST_ZQCL;
          endcase
        end
      end
      ST_ZQCL: begin
        if (ck_rise) begin
          state_d = ST_LOCK;
          ck_load = 1'b1;
          ck_count = 32'(LOCK_CK);
        end
      end
      ST_LOCK: begin
        if (ck_done && ck_rise) begin
          state_d = ST_READY;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_RESET;
    end else if (WARM_RESET && state_q != ST_RESET) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Reset hold length is loaded on entry; a warm request while already in ST_RESET does not reload the timer
  logic reset_load;
  assign reset_load = WARM_RESET && state_q != ST_RESET;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_q <= 32'(RESET_COLD_CYC);
    end else if (reset_load) begin
      hold_q <= 32'(WARM_CYC);
    end else if (state_q == ST_RESET && hold_q != 32'h0000_0000) begin
      hold_q <= hold_q - 32'h0000_0001;
    end
  end

  // ==========================================================
  // Pin drive
  // ==========================================================
  logic reset_n_q;
  logic cke_q;
  logic [3:0] pins_q;
  logic [2:0] ba_q;
  logic [15:0] a_q;
  logic user_go;
  assign REQ_READY = (state_q == ST_READY) && ck_rise && !WARM_RESET;
  assign user_go = REQ_READY && REQ_VALID;
  logic open_err_q;
  assign OPEN_ERR = open_err_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      reset_n_q <= 1'b0;
      cke_q <= 1'b0;
    end else begin
      reset_n_q <= (state_q != ST_RESET) || (hold_q == 32'h0000_0000 && !reset_load);
      cke_q <= (state_q == ST_CKE_UP) || (state_q >= ST_XPR && state_q <= ST_READY);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pins_q <= cmd_pins(CMD_NOP);
      ba_q <= 3'h0;
      a_q <= 16'h0000;
    end else if (state_q != ST_READY && state_q != ST_ZQCL && !(issue && state_q inside {ST_MR2, ST_MR3, ST_MR1})) begin
      if (ck_rise || state_q == ST_RESET) begin
        pins_q <= cmd_pins(CMD_NOP);
      end
    end else if (state_q == ST_ZQCL && ck_rise) begin
      pins_q <= cmd_pins(CMD_ZQCL);
      ba_q <= 3'h0;
      a_q <= 16'h0000 | (16'h0001 << `ADDR_ZQ_LONG_BIT);
    end else if (issue) begin
      pins_q <= cmd_pins(CMD_MRS);
      unique case (state_q)
        ST_MR2: begin
          ba_q <= `BANK_MR3;
          a_q <= MR3_VAL;
        end
        ST_MR3: begin
          ba_q <= `BANK_MR1;
          a_q <= MR1_VAL & ~(16'h0001 << `ADDR_DLL_DIS_BIT);
        end
        default: begin
          ba_q <= `BANK_MR0;
          a_q <= MR0_VAL | (16'h0001 << `ADDR_DLL_RESET_BIT);
        end
      endcase
    end else if (ck_rise) begin
      pins_q <= user_go ? cmd_pins(cmd_e'({1'b0, REQ_CMD})) : cmd_pins(CMD_NOP);
      ba_q <= REQ_BANK;
      a_q <= REQ_ADDR;
    end
  end

  // First mode write is issued from ST_XPR and targets register 2
  logic mr2_now;
  assign mr2_now = issue && state_q == ST_XPR;
  logic [2:0] ba_out;
  logic [15:0] a_out;
  logic [3:0] pins_out;
  logic mr2_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mr2_q <= 1'b0;
    end else if (mr2_now) begin
      mr2_q <= 1'b1;
    end else if (ck_rise) begin
      mr2_q <= 1'b0;
    end
  end
  logic [15:0] mr2_a_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mr2_a_q <= 16'h0000;
    end else if (mr2_now) begin
      mr2_a_q <= MR2_VAL;
    end
  end
  assign pins_out = mr2_q ? cmd_pins(CMD_MRS) : pins_q;
  assign ba_out = mr2_q ? `BANK_MR2 : ba_q;
  assign a_out = mr2_q ? mr2_a_q : a_q;

  // Rows opened per bank; reads or writes to a closed bank raise a sticky flag
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      open_q <= 8'h00;
      open_err_q <= 1'b0;
    end else if (state_q != ST_READY) begin
      open_q <= 8'h00;
    end else if (user_go) begin
      unique case (cmd_e'({1'b0, REQ_CMD}))
        CMD_ACT: open_q[REQ_BANK] <= 1'b1;
        CMD_PRE: open_q <= REQ_ADDR[10] ? 8'h00 : (open_q & ~(8'h01 << REQ_BANK));
        CMD_RD, CMD_WR: begin
          if (!open_q[REQ_BANK]) begin
            open_err_q <= 1'b1;
          end else if (REQ_ADDR[10]) begin
            open_q[REQ_BANK] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign MEM_RESET_N = reset_n_q;
  assign MEM_CKE = cke_q;
  assign MEM_ODT = 1'b0;
  assign {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} = pins_out;
  assign MEM_BA = ba_out;
  assign MEM_A = a_out;
  assign INIT_DONE = (state_q == ST_READY);

  // ==========================================================
  // Checks
  // ==========================================================
  property p_cke_low_at_release;
    @(posedge CLK) disable iff (!RST_N)
      $rose(MEM_RESET_N) |-> !MEM_CKE;
  endproperty
  a_cke_low_at_release: assert property (p_cke_low_at_release) else $error("cke high at reset release");

  property p_cke_stays;
    @(posedge CLK) disable iff (!RST_N || WARM_RESET)
      $fell(MEM_CKE) |-> !MEM_RESET_N || $past(state_q) == ST_RESET;
  endproperty
  a_cke_stays: assert property (p_cke_stays) else $error("cke dropped during init");

  property p_odt_low;
    @(posedge CLK) disable iff (!RST_N)
      !INIT_DONE |-> !MEM_ODT;
  endproperty
  a_odt_low: assert property (p_odt_low) else $error("odt not low");

  property p_mr1_dll;
    @(posedge CLK) disable iff (!RST_N)
      (pins_out == 4'h0 && MEM_BA == `BANK_MR1) |-> !MEM_A[`ADDR_DLL_DIS_BIT];
  endproperty
  a_mr1_dll: assert property (p_mr1_dll) else $error("dll not enabled");

  property p_mr0_reset;
    @(posedge CLK) disable iff (!RST_N)
      (pins_out == 4'h0 && MEM_BA == `BANK_MR0 && !INIT_DONE) |-> MEM_A[`ADDR_DLL_RESET_BIT];
  endproperty
  a_mr0_reset: assert property (p_mr0_reset) else $error("dll reset missing");

  property p_no_cmd_before_cke;
    @(posedge CLK) disable iff (!RST_N)
      !MEM_CKE |-> pins_out == 4'h7;
  endproperty
  a_no_cmd_before_cke: assert property (p_no_cmd_before_cke) else $error("command before cke");

  property p_order;
    @(posedge CLK) disable iff (!RST_N || WARM_RESET)
      (state_q == ST_MR3 && $past(state_q) != ST_MR3) |-> $past(state_q) == ST_MR2;
  endproperty
  a_order: assert property (p_order) else $error("mode order wrong");

  property p_zq_after_mr0;
    @(posedge CLK) disable iff (!RST_N || WARM_RESET)
      (state_q == ST_ZQCL && $past(state_q) != ST_ZQCL) |-> $past(state_q) == ST_MR0;
  endproperty
  a_zq_after_mr0: assert property (p_zq_after_mr0) else $error("calibration out of order");
endmodule

// [ddr3_mem_model.sv]
// Behavioural memory device that checks the controller's initialization steps
`timescale 1ns/1ps
module ddr3_mem_model #(
  parameter int T_COLD_NS = 500,
  parameter int T_WARM_NS = 100,
  parameter int T_EXIT_NS = 1000
)(
  input wire logic reset_n,
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [15:0] a,
  input wire logic odt,
  output int errs,
  output int mrs_cnt,
  output logic [63:0] mr_flat,
  output logic [3:0] last_pins,
  output logic [15:0] last_a,
  output logic [7:0] bank_open,
  output logic term_on,
  output int burst_ck
);
  int ck_n;
  int since_cke;
  int last_mrs;
  logic cold;
  logic zq_done;
  logic in_mrs;
  logic [3:0] pins;
  realtime t_rst;
  realtime t_cke_low;
  realtime t_rel;
  task automatic clear();
    mrs_cnt = 0;
    ck_n = 0;
    last_mrs = 99;
    zq_done = 1'b0;
    in_mrs = 1'b0;
    bank_open = '0;
    term_on = 1'b0;
    burst_ck = 0;
  endtask
  // ==========
  // Reset and clock enable timing
  initial begin
    errs = 0;
    cold = 1'b1;
    t_rst = 0;
    t_cke_low = 0;
    t_rel = 0;
    clear();
  end
  always @(negedge reset_n) begin
    t_rst = $realtime;
    clear();
  end
  always @(negedge cke) begin
    t_cke_low = $realtime;
    if (reset_n === 1'b1 && zq_done !== 1'b1) errs++;
  end
  always @(posedge reset_n) begin
    if (cke !== 1'b0 || $realtime - t_cke_low < 10) errs++;
    if ($realtime - t_rst < (cold ? T_COLD_NS : T_WARM_NS)) errs++;
    cold = 1'b0;
    t_rel = $realtime;
  end
  always @(posedge cke) begin
    if (reset_n !== 1'b1 || $realtime - t_rel < T_EXIT_NS) errs++;
    if (ck_n < 5 || {ras_n, cas_n, we_n} !== 3'h7) errs++;
    since_cke = 0;
  end
  always @(odt) begin
    if (reset_n === 1'b1 && odt !== 1'b0) errs++;
  end
  // ==========
  // Commands registered on the rising memory clock
  always @(posedge ck) begin
    ck_n++;
    since_cke++;
    last_mrs++;
    pins = {cs_n, ras_n, cas_n, we_n};
    if (reset_n === 1'b1 && cke === 1'b1) begin
      term_on = odt;
      if (pins[3] === 1'b0 && pins !== 4'h7) begin
        last_pins = pins;
        last_a = a;
        if (in_mrs && pins !== 4'h0 && pins !== 4'h6) errs++;
        case (pins)
          4'h0: begin
            if (since_cke < 6 || last_mrs < 4) errs++;
            if (mrs_cnt < 4 && ba !== 3'(mrs_cnt < 2 ? mrs_cnt + 2 : 3 - mrs_cnt)) errs++;
            if ((ba === 3'h1 && a[0] !== 1'b0) || (ba === 3'h0 && a[8] !== 1'b1)) errs++;
            if (ba < 4) mr_flat[ba * 16 +: 16] = a;
            mrs_cnt++;
            last_mrs = 0;
            in_mrs = 1'b1;
          end
          4'h6: begin
            if (mrs_cnt != 4 || a[10] !== 1'b1) errs++;
            in_mrs = 1'b0;
            zq_done = 1'b1;
          end
          4'h3: bank_open[ba] = 1'b1;
          4'h2: bank_open = a[10] ? 8'h00 : bank_open & ~(8'h01 << ba);
          4'h4, 4'h5: begin
            if (a[10]) bank_open[ba] = 1'b0;
            burst_ck = (a[12] ? 8 : 4) / 2;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// [ddr3_init_ctrl_test.sv]
// Self-checking bench for the memory initialization controller
`timescale 1ns/1ps
module ddr3_init_ctrl_test;
  localparam int COLD = 50;
  localparam int EXIT = 100;
  localparam int MIN_INIT = EXIT + (6 + 3 * 4 + 512) * 16;
  localparam logic [15:0] MR0V = 16'h0a51;
  localparam logic [15:0] MR1V = 16'h0045;
  localparam logic [15:0] MR2V = 16'h0218;
  localparam logic [15:0] MR3V = 16'h0004;
  logic clk, rst_n, warm, valid, ready, init_done, open_err;
  logic mem_rst_n, mem_ck, cke, cs_n, ras_n, cas_n, we_n, odt, term_on;
  logic [2:0] cmd, bank, ba;
  logic [15:0] addr, a, last_a;
  logic [3:0] last_pins;
  logic [7:0] bank_open;
  logic [63:0] mr_flat;
  int errors, total_checks, merrs, mrs_cnt, burst_ck;
  ddr3_init_ctrl #(.RESET_COLD_CYC(COLD), .RESET_EXIT_CYC(EXIT)) u_dut (
    .CLK(clk), .RST_N(rst_n), .WARM_RESET(warm),
    .MR0_VAL(MR0V), .MR1_VAL(MR1V), .MR2_VAL(MR2V), .MR3_VAL(MR3V),
    .REQ_VALID(valid), .REQ_READY(ready), .REQ_CMD(cmd), .REQ_BANK(bank), .REQ_ADDR(addr),
    .INIT_DONE(init_done), .OPEN_ERR(open_err), .MEM_RESET_N(mem_rst_n), .MEM_CK(mem_ck),
    .MEM_CKE(cke), .MEM_CS_N(cs_n), .MEM_RAS_N(ras_n), .MEM_CAS_N(cas_n), .MEM_WE_N(we_n),
    .MEM_BA(ba), .MEM_A(a), .MEM_ODT(odt));
  ddr3_mem_model #(.T_COLD_NS(COLD * 10), .T_WARM_NS(100), .T_EXIT_NS(EXIT * 10)) u_mem (
    .reset_n(mem_rst_n), .ck(mem_ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .a(a), .odt(odt), .errs(merrs), .mrs_cnt(mrs_cnt), .mr_flat(mr_flat),
    .last_pins(last_pins), .last_a(last_a), .bank_open(bank_open), .term_on(term_on), .burst_ck(burst_ck));
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [2:0] c, input logic [2:0] b, input logic [15:0] ad, input logic [3:0] p);
    int n;
    n = 0;
    valid <= 1'b1;
    cmd <= c;
    bank <= b;
    addr <= ad;
    @(posedge clk);
    while (ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(n < 100, 1'b1);
    valid <= 1'b0;
    repeat (24) @(posedge clk);
    chk(last_pins, p);
    chk(last_a, ad);
  endtask
  task automatic check_init(input string name);
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk(n >= MIN_INIT && n < 20000, 1'b1);
    chk(mrs_cnt, 4);
    chk(mr_flat[47:32], MR2V);
    chk(mr_flat[63:48], MR3V);
    chk(mr_flat[31:16], MR1V & 16'hfffe);
    chk(mr_flat[15:0], MR0V | 16'h0100);
    chk(last_pins, 4'h6);
    chk(term_on, 1'b0);
    chk(merrs, 0);
    $display("test %s done", name);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========
  // Clock, tests and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    warm = 1'b0;
    valid = 1'b0;
    cmd = 3'h0;
    bank = 3'h0;
    addr = 16'h0000;
    errors = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    check_init("cold");
    send(3'h3, 3'h2, 16'h1234, 4'h3);
    chk(bank_open[2], 1'b1);
    send(3'h4, 3'h2, 16'h1408, 4'h5);
    chk(bank_open[2], 1'b0);
    chk(burst_ck, 4);
    chk(open_err, 1'b0);
    send(3'h3, 3'h6, 16'h00ff, 4'h3);
    send(3'h5, 3'h6, 16'h0010, 4'h4);
    chk(burst_ck, 2);
    send(3'h6, 3'h0, 16'h0400, 4'h2);
    chk(bank_open, 8'h00);
    send(3'h7, 3'h0, 16'h0000, 4'h1);
    send(3'h4, 3'h5, 16'h0000, 4'h5);
    chk(open_err, 1'b1);
    $display("test commands done");
    warm <= 1'b1;
    @(posedge clk);
    warm <= 1'b0;
    repeat (3) @(posedge clk);
    chk(mem_rst_n, 1'b0);
    chk(init_done, 1'b0);
    check_init("warm");
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
endmodule
